/* File: verilog/changeover_pkg.sv */
// Summary of operation
// (RULE_01) Auto mode: primary lost, route backup, flag
// (RULE_02) Auto mode: primary back, route primary, show
// (RULE_03) Confirm press clears pending fault indications
// (RULE_04) Manual mode: primary loss flags, no switch
// (RULE_05) Auto mode refuses backup output selection
// (RULE_06) Manual mode routes operator's selected input
// (RULE_07) One mains inlet lost raises its fault
// (RULE_08) Mains inlet restored shows fault fixed
// (RULE_09) Both mains lost: all outputs to primary
// (RULE_10) Defaults: black reference, automatic, primary
// (RULE_11) Power-up starts automatic with primary selected
// (RULE_12) Leaving menu to stand-by saves settings
// (RULE_13) Too many active channels: missing message, confirm
// (RULE_14) Relay channels change over with monitored ones; every relay group follows channel one only
// (RULE_15) Back press steps one level toward stand-by
// (RULE_16) Active channel count up to twelve, from one; a written count of zero is also accepted
// (RULE_17) Fault indications held until acknowledged; a mains inlet loss flag clears when that inlet is restored
package changeover_pkg;
    localparam int          CH_MAX       = 12;
    localparam int          RELAY_GROUPS = 3;
    localparam int          LEVEL_TOP    = 3;

    localparam logic [7:0]  OFF_CFG      = 8'h00;
    localparam logic [7:0]  OFF_MODE     = 8'h04;
    localparam logic [7:0]  OFF_OUTSEL   = 8'h08;
    localparam logic [7:0]  OFF_TYPE     = 8'h0C;
    localparam logic [7:0]  OFF_NAV      = 8'h10;
    localparam logic [7:0]  OFF_ROUTE    = 8'h14;
    localparam logic [7:0]  OFF_FAULT    = 8'h18;
    localparam logic [7:0]  OFF_POWER    = 8'h1C;
    localparam logic [7:0]  OFF_PRESENT  = 8'h20;

    // NAV write bits
    localparam int          NAV_BACK     = 0;
    localparam int          NAV_CONFIRM  = 1;
    localparam int          NAV_ENTER    = 2;
    // FAULT and PRESENT field positions
    localparam int          FLT_LOST_LSB = 0;
    localparam int          FLT_BACK_LSB = 16;
    // POWER field positions
    localparam int          PWR_LOST_LSB = 0;
    localparam int          PWR_FIX_LSB  = 2;
    localparam int          PWR_MISSING  = 4;
    localparam int          PWR_LIVE_LSB = 8;

    typedef enum logic [1:0] {
        SIG_BLACK  = 2'h0,
        SIG_TRI    = 2'h1,
        SIG_DIGITAL = 2'h2,
        SIG_NONE   = 2'h3
    } sig_type_t;

    localparam logic [3:0]  RST_COUNT    = 4'hC;
    localparam logic [11:0] RST_MODE     = 12'hFFF;
    localparam logic [11:0] RST_OUTSEL   = 12'h000;
    localparam logic [23:0] RST_TYPE     = 24'h000000;
endpackage : changeover_pkg

/* File: verilog/sync_stage.sv */
`timescale 1ns/1ns
module sync_stage #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sync_stage

/* File: verilog/signal_changeover_control.sv */
`timescale 1ns/1ns
module signal_changeover_control #(
    parameter int N = changeover_pkg::CH_MAX
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic [7:0]         address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    input  wire logic [3:0]         byteenable,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    input  wire logic [N-1:0]       primary_present,
    input  wire logic [N-1:0]       backup_present,
    input  wire logic [1:0]         mains_ok,
    output logic      [N-1:0]       route_backup,
    output logic      [changeover_pkg::RELAY_GROUPS-1:0] relay_backup,
    output logic                    nvm_save
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic [N-1:0]  prim_s;
    logic [N-1:0]  prim_d;
    logic [N-1:0]  back_s;
    logic [1:0]    mains_s;
    logic [1:0]    mains_d;
    logic          ack;
    logic [3:0]    count;
    logic [N-1:0]  mode_auto;
    logic [N-1:0]  sel_backup;
    logic [23:0]   sig_type;
    logic [1:0]    level;
    logic [N-1:0]  flt_lost;
    logic [N-1:0]  flt_back;
    logic [1:0]    pwr_lost;
    logic [1:0]    pwr_fix;
    logic          missing;
    logic          missing_d;
    logic [N-1:0]  next_route;
    logic [31:0]   rd_mux;
    // Synchronisers hold zero for two edges after reset; edges are ignored through the third edge
    logic [2:0]    warm;
    wire           live = warm[2];

    sync_stage #(.W(N)) u_sync_prim (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (primary_present),
        .q      (prim_s)
    );
    sync_stage #(.W(N)) u_sync_back (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (backup_present),
        .q      (back_s)
    );
    sync_stage #(.W(2)) u_sync_mains (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (mains_ok),
        .q      (mains_s)
    );

    // Bus decode: one wait state, then the access completes
    wire        req      = read | write;
    wire        wr_go    = write & ack;
    wire [31:0] bmask    = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire [31:0] wmasked  = writedata & bmask;
    wire        wr_cfg   = wr_go & (address == changeover_pkg::OFF_CFG);
    wire        wr_mode  = wr_go & (address == changeover_pkg::OFF_MODE);
    wire        wr_sel   = wr_go & (address == changeover_pkg::OFF_OUTSEL);
    wire        wr_type  = wr_go & (address == changeover_pkg::OFF_TYPE);
    wire        wr_nav   = wr_go & (address == changeover_pkg::OFF_NAV);
    wire        back_p   = wr_nav & wmasked[changeover_pkg::NAV_BACK];
    wire        confirm  = wr_nav & wmasked[changeover_pkg::NAV_CONFIRM];
    wire        enter_p  = wr_nav & wmasked[changeover_pkg::NAV_ENTER];
    assign waitrequest   = req & ~ack;

    wire [31:0] new_cfg  = ({28'h0000000, count} & ~bmask) | wmasked;
    wire [31:0] new_mode = ({20'h00000, mode_auto} & ~bmask) | wmasked;
    wire [31:0] new_sel  = ({20'h00000, sel_backup} & ~bmask) | wmasked;
    wire [31:0] new_type = ({8'h00, sig_type} & ~bmask) | wmasked;

    // Counts above the channel total are clamped
    wire [3:0]  cnt_wr   = (new_cfg[3:0] > 4'(N)) ? 4'(N) : new_cfg[3:0];
    wire [N-1:0] mode_nx = wr_mode ? new_mode[N-1:0] : mode_auto;

    wire          both_off = ~|mains_s;
    wire [N-1:0]  active;
    wire [N-1:0]  lost_ev  = prim_d & ~prim_s & active & {N{live}};
    wire [N-1:0]  back_ev  = ~prim_d & prim_s & active & {N{live}};
    wire          miss_now = |(active & ~prim_s);
    wire [1:0]    mains_dn = mains_d & ~mains_s & {2{live}};
    wire [1:0]    mains_up = ~mains_d & mains_s & {2{live}};

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            assign active[i] = (4'(i) < count); // see RULE_16
            // Power loss, idle channels and auto with good primary all go to primary
            assign next_route[i] = both_off ? 1'b0 :           // see RULE_09
                                   !active[i] ? 1'b0 :
                                   mode_auto[i] ? ~prim_s[i] : // see RULE_01 see RULE_02
                                   sel_backup[i];              // see RULE_04 see RULE_06

            a_auto_refuse_sel: assert property (mode_auto[i] |-> !sel_backup[i]) // see RULE_05
                else $error("backup selection held in automatic mode");
            a_auto_loss_route: assert property (
                mode_auto[i] && !both_off && lost_ev[i] && !wr_mode && !wr_cfg
                |=> route_backup[i] && flt_lost[i]) // see RULE_01
                else $error("primary loss did not move to backup");
            a_manual_hold_route: assert property (
                !mode_nx[i] && !mode_auto[i] && active[i] && !both_off && !wr_sel && !wr_cfg
                |=> route_backup[i] == $past(sel_backup[i])) // see RULE_04
                else $error("manual route differs from selection");
        end
    endgenerate

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack       <= 1'b0;
            readdata  <= 32'h00000000;
            prim_d    <= '0;
            mains_d   <= 2'h3;
            missing_d <= 1'b0;
            warm      <= 3'h0;
        end else begin
            warm      <= {warm[1:0], 1'b1};
            ack       <= req & ~ack;
            if (req & ~ack) begin
                readdata <= rd_mux;
            end
            prim_d    <= prim_s;
            mains_d   <= mains_s;
            missing_d <= miss_now;
        end
    end

    always_comb begin
        case (address)
            changeover_pkg::OFF_CFG:     rd_mux = {28'h0000000, count};
            changeover_pkg::OFF_MODE:    rd_mux = 32'(mode_auto);
            changeover_pkg::OFF_OUTSEL:  rd_mux = 32'(sel_backup);
            changeover_pkg::OFF_TYPE:    rd_mux = {8'h00, sig_type};
            changeover_pkg::OFF_NAV:     rd_mux = {30'h00000000, level};
            changeover_pkg::OFF_ROUTE:   rd_mux = 32'(route_backup);
            changeover_pkg::OFF_FAULT:   rd_mux = 32'(flt_lost) | (32'(flt_back) << changeover_pkg::FLT_BACK_LSB);
            changeover_pkg::OFF_POWER:   rd_mux = {22'h000000, mains_s, 3'h0, missing, pwr_fix, pwr_lost};
            changeover_pkg::OFF_PRESENT: rd_mux = 32'(prim_s) | (32'(back_s) << changeover_pkg::FLT_BACK_LSB);
            default:                     rd_mux = 32'h00000000;
        endcase
    end

    // Configuration registers; reset gives the factory setup
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count      <= changeover_pkg::RST_COUNT;
            mode_auto  <= changeover_pkg::RST_MODE;   // see RULE_10 see RULE_11
            sel_backup <= changeover_pkg::RST_OUTSEL; // see RULE_10 see RULE_11
            sig_type   <= changeover_pkg::RST_TYPE;   // see RULE_10
        end else begin
            if (wr_cfg) begin
                count <= cnt_wr; // see RULE_16
            end
            mode_auto <= mode_nx;
            // Backup requests are dropped on channels in automatic mode
            if (wr_sel) begin
                sel_backup <= new_sel[N-1:0] & ~mode_nx; // see RULE_05
            end else begin
                sel_backup <= sel_backup & ~mode_nx;
            end
            if (wr_type) begin
                sig_type <= new_type[23:0];
            end
        end
    end

    // Routing; relay groups share the edge with the monitored channels
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            route_backup <= '0;
            relay_backup <= '0;
        end else begin
            route_backup <= next_route;
            relay_backup <= {changeover_pkg::RELAY_GROUPS{next_route[0]}}; // see RULE_14
        end
    end

    // Sticky indications: a new event wins over a confirm in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flt_lost <= '0;
            flt_back <= '0;
            pwr_lost <= 2'h0;
            pwr_fix  <= 2'h0;
            missing  <= 1'b0;
        end else begin
            flt_lost <= lost_ev | (flt_lost & ~{N{confirm}});                 // see RULE_01 see RULE_03 see RULE_17
            flt_back <= back_ev | (flt_back & ~{N{confirm}});                 // see RULE_02 see RULE_17
            pwr_lost <= mains_dn | (pwr_lost & ~{2{confirm}} & ~mains_up);     // see RULE_07
            pwr_fix  <= (mains_up & (pwr_lost | pwr_fix)) | (pwr_fix & ~{2{confirm}} & ~mains_dn); // see RULE_08
            missing  <= (miss_now & ~missing_d & live) | (missing & ~confirm); // see RULE_13
        end
    end

    // Menu depth: zero is the stand-by screen
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            level    <= 2'h0;
            nvm_save <= 1'b0;
        end else begin
            nvm_save <= back_p & (level == 2'h1); // see RULE_12
            if (back_p && level != 2'h0) begin
                level <= level - 2'h1; // see RULE_15
            end else if (enter_p && level != 2'(changeover_pkg::LEVEL_TOP)) begin
                level <= level + 2'h1;
            end
        end
    end

    a_bus_one_wait: assert property (req && !ack |=> !req || !waitrequest)
        else $error("access not answered after one wait cycle");
    a_confirm_clears: assert property (confirm && lost_ev == '0 |=> flt_lost == '0) // see RULE_03
        else $error("confirm left a primary fault pending");
    a_mains_fault_set: assert property (mains_dn[0] |=> pwr_lost[0]) // see RULE_07
        else $error("inlet loss not flagged");
    a_mains_fixed: assert property (mains_up[1] && pwr_lost[1] |=> pwr_fix[1] && !pwr_lost[1]) // see RULE_08
        else $error("inlet restore not shown as fixed");
    a_power_off_primary: assert property (both_off |=> route_backup == '0 && relay_backup == '0) // see RULE_09
        else $error("outputs not on primary with both inlets lost");
    a_save_on_exit: assert property (back_p && level == 2'h1 |=> nvm_save && level == 2'h0) // see RULE_12
        else $error("leaving the menu did not save");
    a_back_steps_up: assert property (back_p && level == 2'h2 |=> level == 2'h1 ##1 !nvm_save) // see RULE_15
        else $error("back press did not step one level");
    a_relay_follows: assert property (route_backup[0] == relay_backup[0]) // see RULE_14
        else $error("relay group out of step with channel one");
    a_missing_held: assert property (missing && !confirm |=> missing) // see RULE_13
        else $error("missing message dropped without confirm");
endmodule : signal_changeover_control

/* File: verification/signal_sources.sv */
`timescale 1ns/1ns
module signal_sources #(
    parameter int N = 12
) (
    input  wire logic         clock,
    input  wire logic [N-1:0] prim_on,
    input  wire logic [1:0]   inlet_on,
    output logic      [N-1:0] primary_present,
    output logic      [N-1:0] backup_present,
    output logic      [1:0]   mains_ok
);
    // Sources and inlets start live, so reset brings no loss event
    initial begin
        primary_present = '1;
        backup_present = '1;
        mains_ok = 2'h3;
    end
    always @(posedge clock) begin
        primary_present <= prim_on;
        backup_present <= '1;
        mains_ok <= inlet_on;
    end
endmodule : signal_sources

/* File: verification/tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    localparam int N = changeover_pkg::CH_MAX;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [N-1:0] primary_present, backup_present, route_backup, prim_on = '1;
    logic [1:0]  mains_ok, inlet_on = 2'h3;
    logic [2:0]  relay_backup;
    logic        nvm_save;
    int          n_errors = 0;
    int          n_tests = 0;
    int          n_saves = 0;
    always #5 clock = ~clock;
    always @(posedge clock) if (nvm_save === 1'b1) n_saves <= n_saves + 1;
    signal_changeover_control #(.N(N)) u_dut (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .primary_present(primary_present), .backup_present(backup_present), .mains_ok(mains_ok),
        .route_backup(route_backup), .relay_backup(relay_backup), .nvm_save(nvm_save));
    signal_sources #(.N(N)) u_src (.clock(clock), .prim_on(prim_on), .inlet_on(inlet_on),
        .primary_present(primary_present), .backup_present(backup_present), .mains_ok(mains_ok));
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= we;
        read <= ~we;
        // Request holds until the edge that sees waitrequest low
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50) n_errors++;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, e, q & m)
    endtask : rchk
    // Four edges reach the outputs; five leaves margin
    task automatic pins(input logic [N-1:0] p, input logic [1:0] m);
        prim_on <= p;
        inlet_on <= m;
        repeat (5) @(posedge clock);
    endtask : pins
    task automatic confirm;
        wr(changeover_pkg::OFF_NAV, 32'h1 << changeover_pkg::NAV_CONFIRM);
    endtask : confirm
    task automatic t_defaults;
        rchk("cfg", changeover_pkg::OFF_CFG, 32'hF, 32'hC);
        rchk("mode", changeover_pkg::OFF_MODE, 32'hFFF, 32'hFFF);
        rchk("outsel", changeover_pkg::OFF_OUTSEL, 32'hFFF, 32'h0);
        rchk("type", changeover_pkg::OFF_TYPE, 32'hFFFFFF, 32'h0);
        rchk("route", changeover_pkg::OFF_ROUTE, 32'hFFF, 32'h0);
        rchk("present", changeover_pkg::OFF_PRESENT, 32'h0FFF0FFF, 32'h0FFF0FFF);
        rchk("power", changeover_pkg::OFF_POWER, 32'h31F, 32'h300);
        rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        wr(changeover_pkg::OFF_CFG, 32'hF);
        rchk("clamp", changeover_pkg::OFF_CFG, 32'hF, 32'hC);
    endtask : t_defaults
    task automatic t_auto;
        confirm();
        pins(12'hFFE, 2'h3);
        `CHK("route", 12'h001, route_backup)
        `CHK("relay", 3'h7, relay_backup)
        rchk("fault", changeover_pkg::OFF_FAULT, 32'h0FFF0FFF, 32'h1);
        rchk("missing", changeover_pkg::OFF_POWER, 32'h10, 32'h10);
        pins(12'hFFF, 2'h3);
        `CHK("route", 12'h000, route_backup)
        `CHK("relay", 3'h0, relay_backup)
        rchk("fault", changeover_pkg::OFF_FAULT, 32'h0FFF0FFF, 32'h00010001);
        confirm();
        rchk("fault", changeover_pkg::OFF_FAULT, 32'h0FFF0FFF, 32'h0);
        rchk("missing", changeover_pkg::OFF_POWER, 32'h10, 32'h0);
    endtask : t_auto
    task automatic t_manual;
        wr(changeover_pkg::OFF_OUTSEL, 32'hFFF);
        rchk("outsel", changeover_pkg::OFF_OUTSEL, 32'hFFF, 32'h0);
        `CHK("route", 12'h000, route_backup)
        wr(changeover_pkg::OFF_MODE, 32'hFFE);
        wr(changeover_pkg::OFF_OUTSEL, 32'h1);
        repeat (3) @(posedge clock);
        `CHK("route", 12'h001, route_backup)
        `CHK("relay", 3'h7, relay_backup)
        wr(changeover_pkg::OFF_OUTSEL, 32'h0);
        repeat (3) @(posedge clock);
        `CHK("route", 12'h000, route_backup)
        pins(12'hFFE, 2'h3);
        `CHK("route", 12'h000, route_backup)
        rchk("fault", changeover_pkg::OFF_FAULT, 32'hFFF, 32'h1);
        pins(12'hFFF, 2'h3);
        confirm();
    endtask : t_manual
    task automatic t_mains;
        logic [1:0] b;
        for (int k = 0; k < 2; k++) begin
            b = 2'h1 << k;
            pins(12'hFFF, 2'h3 ^ b);
            rchk("lost", changeover_pkg::OFF_POWER, 32'h303, {22'h0, 2'h3 ^ b, 6'h0, b});
            pins(12'hFFF, 2'h3);
            rchk("fixed", changeover_pkg::OFF_POWER, {28'h0, b, b}, {28'h0, b, 2'h0});
        end
        wr(changeover_pkg::OFF_MODE, 32'hFFE);
        wr(changeover_pkg::OFF_OUTSEL, 32'h1);
        pins(12'hFFF, 2'h0);
        `CHK("route", 12'h000, route_backup)
        `CHK("relay", 3'h0, relay_backup)
        pins(12'hFFF, 2'h3);
        wr(changeover_pkg::OFF_MODE, 32'hFFF);
        confirm();
    endtask : t_mains
    task automatic t_menu;
        int s0;
        s0 = n_saves;
        repeat (4) wr(changeover_pkg::OFF_NAV, 32'h4);
        wr(changeover_pkg::OFF_NAV, 32'h1);
        rchk("level", changeover_pkg::OFF_NAV, 32'h3, 32'h2);
        wr(changeover_pkg::OFF_NAV, 32'h1);
        `CHK("nosave", s0, n_saves)
        wr(changeover_pkg::OFF_NAV, 32'h1);
        wr(changeover_pkg::OFF_NAV, 32'h1);
        rchk("level", changeover_pkg::OFF_NAV, 32'h3, 32'h0);
        `CHK("save", s0 + 1, n_saves)
    endtask : t_menu
    task automatic t_inactive;
        wr(changeover_pkg::OFF_CFG, 32'h1);
        pins(12'hFDF, 2'h3);
        `CHK("route", 12'h000, route_backup)
        rchk("fault", changeover_pkg::OFF_FAULT, 32'hFFF, 32'h0);
        pins(12'hFFF, 2'h3);
        wr(changeover_pkg::OFF_CFG, 32'hC);
        confirm();
    endtask : t_inactive
    task automatic end_of_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (5) @(posedge clock);
        t_defaults();
        t_auto();
        t_manual();
        t_mains();
        t_menu();
        t_inactive();
        end_of_test();
    end
endmodule : tb
